// file: shared/cfb_pkg.sv
/*
 * Shared types and constants for the fast-termination and CPU-space
 * bus cycle engine.
 * Assumes a 24-bit external address bus and a 16-bit data bus.
 */
package cfb_pkg;
	// ------------------------------------------------------------
	// Encodings
	// ------------------------------------------------------------
	localparam logic [3:0] ACK_FAST     = 4'he;
	localparam logic [3:0] ACK_EXT_ONLY = 4'hf;
	localparam logic [2:0] SPACE_CPU    = 3'h7;
	localparam logic [3:0] CPU_BREAKPOINT_PIN     = 4'h0;
	localparam logic [3:0] CPU_LOW_POWER_STOP   = 4'h3;
	localparam logic [3:0] CPU_IACK     = 4'hf;
	localparam logic [2:0] HW_BREAKPOINT_PIN_NUM  = 3'h7;
	localparam logic [23:0] LOW_POWER_STOP_ADDR = 24'h03fffe;
	localparam logic [1:0] SIZE_WORD    = 2'h2;
	localparam logic [1:0] ACK_16BIT_N  = 2'h1;
	localparam logic [1:0] ACK_8BIT_N   = 2'h2;
	// ------------------------------------------------------------
	// Timing: first cycle index at which termination may be taken
	// ------------------------------------------------------------
	localparam logic [1:0] FAST_MIN_CYC = 2'h1;
	localparam logic [1:0] REG_MIN_CYC  = 2'h2;

	typedef enum logic [1:0] {
		CFB_K_NORMAL = 2'h0,
		CFB_K_SWBKPT = 2'h1,
		CFB_K_LOW_POWER_STOP = 2'h2,
		CFB_K_HWBKPT = 2'h3
	} cfb_kind_t;

	typedef struct packed {
		cfb_kind_t   kind;
		logic        rw;
		logic [2:0]  space;
		logic [1:0]  size;
		logic [23:0] addr;
		logic [15:0] data;
	} cfb_req_t;

	typedef struct packed {
		logic        match;
		logic [3:0]  ack_field;
	} cfb_cs_t;

	typedef struct packed {
		logic [23:0] addr;
		logic [2:0]  space_code;
		logic [1:0]  transfer_size;
		logic        rw;
		logic        address_strobe_n;
		logic        data_strobe_n;
	} cfb_bus_t;
endpackage

// file: rtl/cfb_engine.sv
/*
 * Bus cycle engine: fast-termination and regular external cycles,
 * breakpoint acknowledge and low-power-stop broadcast CPU-space cycles.
 * Assumes chip-select match and acknowledge field arrive on sys_clk from
 * the chip-select logic, and that the core holds its request until taken.
 */
// Functional notes
// - Fast chip-select ends a transfer in two clocks, synchronous to sys_clk.
// - One wait counter for all chip-selects, loaded from the matching one.
// - Fast cycle drives address and size, then acknowledges internally.
// - External acknowledge always ends a cycle; ack field only adds internal ack.
// - Held external ack gives three-clock cycles except for fast chip-selects.
// - Ack field code 1110 selects two-clock internally acknowledged access.
// - Fast cycles assert data strobe on reads, never on writes.
// - Three-bit space code, 7 is CPU space, valid while address strobe low.
// - CPU space type on address 19:16: 0 breakpoint, 3 stop, F interrupt.
// - Software breakpoint: word read, type 0, opcode bits on 4:2, bit1 clear.
// - Software breakpoint answered by bus error or word plus ack, two 8-bit reads.
// - Software breakpoint ended by bus error raises illegal-instruction trap.
// - Breakpoint pin runs a type 0 read with number 111 and bit1 set.
// - Hardware breakpoint bus error traps; an acknowledge drops the breakpoint.
// - Prefetch-aligned breakpoint tags instruction, flush cancels; operand traps at end.
// - Low-power stop writes the interrupt mask to CPU space 3FFFE.
// - Stop broadcast acked internally, fast write timing, shown only when bus owned.
// - Bus error during the stop broadcast is ignored.
// - Stop mode ends on reset or interrupt above the stored mask.
`timescale 1ns/10ps
module cfb_engine (
	input  wire logic              sys_clk,
	input  wire logic              reset_n,
	input  wire cfb_pkg::cfb_req_t req,
	input  wire logic              req_valid,
	output logic                   req_taken,
	input  wire cfb_pkg::cfb_cs_t  cs,
	input  wire logic              bus_owned,
	input  wire logic [1:0]        data_size_ack_n,
	input  wire logic              bus_error_in_n,
	input  wire logic              breakpoint_pin_n,
	input  wire logic [15:0]       data_in,
	output logic [15:0]            data_out,
	output logic                   data_oe,
	output cfb_pkg::cfb_bus_t      bus,
	output logic                   done,
	output logic                   done_bus_error_in,
	output logic [15:0]            rdata,
	input  wire logic              fetch_is_prefetch,
	input  wire logic              pipe_flush,
	input  wire logic              instr_end,
	output logic                   illegal_trap,
	output logic                   breakpoint_pin_trap,
	output logic                   low_power_stop,
	output logic [2:0]             stop_mask,
	input  wire logic [2:0]        irq_level
);
	import cfb_pkg::*;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_RUN  = 3'b010,
		ST_END  = 3'b100
	} cfb_state_t;

	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	logic [19:0] meta_q;
	logic [19:0] sync_q;

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			meta_q <= 20'hfffff;
			sync_q <= 20'hfffff;
		end else begin
			meta_q <= {data_size_ack_n, bus_error_in_n, breakpoint_pin_n, data_in};
			sync_q <= meta_q;
		end
	end

	logic [1:0]  ack_n_s;
	logic        bus_error_in_s;
	logic        breakpoint_pin_s;
	logic [15:0] din_s;

	assign ack_n_s = sync_q[19:18];
	assign bus_error_in_s  = !sync_q[17];
	assign breakpoint_pin_s  = !sync_q[16];
	assign din_s   = sync_q[15:0];

	// ------------------------------------------------------------
	// Cycle engine state
	// ------------------------------------------------------------
	cfb_state_t  state_q, state_d;
	cfb_req_t    cur_q, cur_d;
	cfb_bus_t    bus_q, bus_d;
	logic        fast_q, fast_d;
	logic        intack_q, intack_d;
	logic        shown_q, shown_d;
	logic [3:0]  wait_q, wait_d;
	logic [1:0]  cyc_q, cyc_d;
	logic        half_q, half_d;
	logic [15:0] rdata_q, rdata_d;
	logic [15:0] dout_q, dout_d;
	logic        doe_q, doe_d;
	logic        taken_q, taken_d;
	logic        done_q, done_d;
	logic        dberr_q, dberr_d;
	logic        ill_q, ill_d;
	logic        breakpoint_pin_prev_q;
	logic        hw_pend_q, hw_pend_d;
	logic        tag_q, tag_d;
	logic        trap_pend_q, trap_pend_d;
	logic        trap_q, trap_d;
	logic        stop_q, stop_d;
	logic [2:0]  mask_q, mask_d;
	cfb_req_t    hw_req;
	logic        ext_ack;
	logic        min_ok;
	logic        int_ok;
	logic        term_ok;
	logic        term_err;
	// Pin breakpoint: word read of type 0, number on bits 4:2, bit 1 set
	assign hw_req = '{kind: CFB_K_HWBKPT, rw: 1'b1, space: SPACE_CPU, size: SIZE_WORD,
		addr: {4'h0, CPU_BREAKPOINT_PIN, 11'h000, HW_BREAKPOINT_PIN_NUM, 1'b1, 1'b0}, data: 16'h0000};

	// Either acknowledge line low ends the cycle, whatever the ack field says
	assign ext_ack  = (ack_n_s != 2'h3);
	assign min_ok   = cyc_q >= (fast_q ? FAST_MIN_CYC : REG_MIN_CYC);
	assign int_ok   = intack_q && (wait_q == 4'h0);
	// Stop broadcast never sees bus error, and an unshown cycle sees no pins
	assign term_err = bus_error_in_s && shown_q && (cur_q.kind != CFB_K_LOW_POWER_STOP);
	assign term_ok  = int_ok || (ext_ack && shown_q);

	always_comb begin
		state_d     = state_q;
		cur_d       = cur_q;
		bus_d       = bus_q;
		fast_d      = fast_q;
		intack_d    = intack_q;
		shown_d     = shown_q;
		wait_d      = wait_q;
		cyc_d       = cyc_q;
		half_d      = half_q;
		rdata_d     = rdata_q;
		dout_d      = dout_q;
		doe_d       = doe_q;
		taken_d     = 1'b0;
		done_d      = 1'b0;
		dberr_d     = 1'b0;
		ill_d       = 1'b0;
		trap_d      = 1'b0;
		hw_pend_d   = hw_pend_q;
		tag_d       = tag_q;
		trap_pend_d = trap_pend_q;
		stop_d      = stop_q;
		mask_d      = mask_q;
		// Breakpoint pin edge: remember whether it landed on a prefetch
		if (breakpoint_pin_s && !breakpoint_pin_prev_q) begin
			hw_pend_d = 1'b1;
			tag_d     = fetch_is_prefetch;
		end
		// Trap delivery at the instruction boundary
		if (trap_pend_q && pipe_flush && tag_q) begin
			trap_pend_d = 1'b0;
		end else if (trap_pend_q && instr_end) begin
			trap_pend_d = 1'b0;
			trap_d      = 1'b1;
		end
		if (stop_q && (irq_level > mask_q)) begin
			stop_d = 1'b0;
		end
		unique case (state_q)
			ST_IDLE: begin
				if (hw_pend_q || (req_valid && !stop_q)) begin
					cur_d     = hw_pend_q ? hw_req : req;
					taken_d   = !hw_pend_q;
					hw_pend_d = breakpoint_pin_s && !breakpoint_pin_prev_q; // A new pin edge wins over the clear
					half_d    = 1'b0;
					if (!hw_pend_q && req.kind == CFB_K_SWBKPT) begin
						cur_d.rw    = 1'b1;
						cur_d.space = SPACE_CPU;
						cur_d.size  = SIZE_WORD;
						cur_d.addr  = {4'h0, CPU_BREAKPOINT_PIN, 11'h000, req.data[2:0],
							1'b0, 1'b0};
					end else if (!hw_pend_q && req.kind == CFB_K_LOW_POWER_STOP) begin
						cur_d.rw    = 1'b0;
						cur_d.space = SPACE_CPU;
						cur_d.size  = SIZE_WORD;
						cur_d.addr  = LOW_POWER_STOP_ADDR;
						cur_d.data  = {13'h0000, req.data[2:0]};
					end
					state_d = ST_RUN;
				end
				// Chip-select values are sampled in the launch cycle
				if (state_d == ST_RUN) begin
					if (cur_d.kind == CFB_K_LOW_POWER_STOP) begin
						fast_d   = 1'b1;
						intack_d = 1'b1;
						wait_d   = 4'h0;
						shown_d  = bus_owned;
					end else begin
						fast_d   = cs.match && (cs.ack_field == ACK_FAST);
						intack_d = cs.match && (cs.ack_field != ACK_EXT_ONLY);
						wait_d   = fast_d ? 4'h0 : cs.ack_field;
						shown_d  = 1'b1;
					end
					cyc_d = 2'h0;
					bus_d.addr          = cur_d.addr;
					bus_d.transfer_size = cur_d.size;
					bus_d.space_code    = cur_d.space;
					bus_d.rw            = cur_d.rw;
					bus_d.address_strobe_n = !shown_d;
					// Fast reads strobe data at once; fast writes never do
					bus_d.data_strobe_n = !(shown_d && cur_d.rw && fast_d);
					dout_d = cur_d.data;
					doe_d  = shown_d && !cur_d.rw;
				end
			end
			ST_RUN: begin
				if (cyc_q != 2'h3) begin
					cyc_d = cyc_q + 2'h1;
				end
				// Regular reads raise data strobe one clock after address strobe, writes two clocks after
				if (!fast_q && shown_q && (cur_q.rw || cyc_q != 2'h0)) begin
					bus_d.data_strobe_n = 1'b0;
				end
				if (min_ok && (term_err || term_ok)) begin
					state_d                = ST_END;
					bus_d.address_strobe_n = 1'b1;
					bus_d.data_strobe_n    = 1'b1;
					doe_d                  = 1'b0;
				end else if (min_ok && wait_q != 4'h0) begin
					wait_d = wait_q - 4'h1;
				end
			end
			ST_END: begin
				state_d = ST_IDLE;
				done_d  = 1'b1;
				if (term_err) begin
					dberr_d = 1'b1;
					if (cur_q.kind == CFB_K_SWBKPT) begin
						ill_d = 1'b1;
					end else if (cur_q.kind == CFB_K_HWBKPT) begin
						trap_pend_d = 1'b1;
					end
				end else if (cur_q.kind == CFB_K_LOW_POWER_STOP) begin
					stop_d = 1'b1;
					mask_d = cur_q.data[2:0];
				end else if (cur_q.rw && cur_q.kind != CFB_K_HWBKPT) begin
					// Byte port on a breakpoint word: fetch the low byte next
					if (cur_q.kind == CFB_K_SWBKPT && ack_n_s == ACK_8BIT_N
						&& !half_q) begin
						rdata_d[15:8] = din_s[15:8];
						half_d        = 1'b1;
						done_d        = 1'b0;
						cur_d.addr    = cur_q.addr | 24'h000001;
						bus_d.addr    = cur_q.addr | 24'h000001;
						bus_d.address_strobe_n = 1'b0;
						cyc_d   = 2'h0;
						wait_d  = fast_q ? 4'h0 : cs.ack_field;
						state_d = ST_RUN;
					end else if (half_q) begin
						rdata_d[7:0] = din_s[15:8];
					end else begin
						rdata_d = din_s;
					end
				end
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			state_q     <= ST_IDLE;
			cur_q       <= '0;
			bus_q       <= '{addr: 24'h000000, space_code: 3'h0, transfer_size: 2'h0,
				rw: 1'b1, address_strobe_n: 1'b1, data_strobe_n: 1'b1};
			fast_q      <= 1'b0;
			intack_q    <= 1'b0;
			shown_q     <= 1'b0;
			wait_q      <= 4'h0;
			cyc_q       <= 2'h0;
			half_q      <= 1'b0;
			rdata_q     <= 16'h0000;
			dout_q      <= 16'h0000;
			doe_q       <= 1'b0;
			taken_q     <= 1'b0;
			done_q      <= 1'b0;
			dberr_q     <= 1'b0;
			ill_q       <= 1'b0;
			breakpoint_pin_prev_q <= 1'b0;
			hw_pend_q   <= 1'b0;
			tag_q       <= 1'b0;
			trap_pend_q <= 1'b0;
			trap_q      <= 1'b0;
			stop_q      <= 1'b0;
			mask_q      <= 3'h7;
		end else begin
			state_q     <= state_d;
			cur_q       <= cur_d;
			bus_q       <= bus_d;
			fast_q      <= fast_d;
			intack_q    <= intack_d;
			shown_q     <= shown_d;
			wait_q      <= wait_d;
			cyc_q       <= cyc_d;
			half_q      <= half_d;
			rdata_q     <= rdata_d;
			dout_q      <= dout_d;
			doe_q       <= doe_d;
			taken_q     <= taken_d;
			done_q      <= done_d;
			dberr_q     <= dberr_d;
			ill_q       <= ill_d;
			breakpoint_pin_prev_q <= breakpoint_pin_s;
			hw_pend_q   <= hw_pend_d;
			tag_q       <= tag_d;
			trap_pend_q <= trap_pend_d;
			trap_q      <= trap_d;
			stop_q      <= stop_d;
			mask_q      <= mask_d;
		end
	end

	assign req_taken      = taken_q;
	assign bus            = bus_q;
	assign data_out       = dout_q;
	assign data_oe        = doe_q;
	assign done           = done_q;
	assign done_bus_error_in      = dberr_q;
	assign rdata          = rdata_q;
	assign illegal_trap   = ill_q;
	assign breakpoint_pin_trap      = trap_q;
	assign low_power_stop = stop_q;
	assign stop_mask      = mask_q;
endmodule

// file: verif/cfb_engine_checker.sv
/* Checker of fast, regular and CPU-space cycle timing at the engine ports.
   Assumes it is bound onto cfb_engine: one clock, asynchronous low reset. */
`timescale 1ns/10ps
module cfb_engine_checker
	import cfb_pkg::*;
(
	input wire logic		sys_clk,
	input wire logic		reset_n,
	input wire cfb_pkg::cfb_cs_t	cs,
	input wire logic [1:0]		data_size_ack_n,
	input wire cfb_pkg::cfb_bus_t	bus,
	input wire logic		done,
	input wire logic		done_bus_error_in,
	input wire logic		illegal_trap,
	input wire logic		low_power_stop,
	input wire logic [2:0]		stop_mask,
	input wire logic [2:0]		irq_level
);
	// ----------------------------------------
	// Sequences
	// ----------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	wire as_n = bus.address_strobe_n;
	wire fast = cs.match && cs.ack_field == ACK_FAST;
	wire cpu = bus.space_code == SPACE_CPU;
	sequence start_s; $fell(as_n); endsequence
	sequence fast_s; start_s ##0 fast; endsequence
	sequence held_s; (data_size_ack_n != 2'h3) [*3]; endsequence
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	a_fast_length: assert property (fast_s |=> !as_n ##1 as_n)
		else $error("fast cycle length wrong");
	a_fast_done: assert property (fast_s |-> ##3 done && !done_bus_error_in)
		else $error("fast cycle not acknowledged internally");
	a_fast_rd_ds: assert property (fast_s ##0 bus.rw |-> (!bus.data_strobe_n)[*2])
		else $error("fast read without data strobe");
	a_fast_wr_ds: assert property (fast_s ##0 !bus.rw |-> bus.data_strobe_n[*3])
		else $error("fast write asserted data strobe");
	a_held_ack: assert property (held_s ##0 start_s ##0 !fast |=> !as_n ##1 !as_n ##1 as_n)
		else $error("held acknowledge cycle length wrong");
	a_space_stable: assert property (!as_n && !$fell(as_n) |-> $stable(bus.space_code))
		else $error("space code moved under strobe");
	a_cpu_type: assert property (start_s ##0 cpu |->
		bus.addr[19:16] inside {CPU_BREAKPOINT_PIN, CPU_LOW_POWER_STOP, CPU_IACK})
		else $error("bad CPU space type");
	a_hw_breakpoint_pin: assert property (start_s ##0 cpu && bus.addr[19:16] == CPU_BREAKPOINT_PIN && bus.addr[1]
		|-> bus.rw && bus.addr[4:2] == HW_BREAKPOINT_PIN_NUM && bus.transfer_size == SIZE_WORD)
		else $error("bad pin breakpoint cycle");
	a_stop_addr: assert property (start_s ##0 cpu && !bus.rw |-> bus.addr == LOW_POWER_STOP_ADDR)
		else $error("bad stop broadcast address");
	a_illegal_trap: assert property (illegal_trap |-> done && done_bus_error_in)
		else $error("illegal trap without bus error end");
	a_stop_exit: assert property (low_power_stop && irq_level > stop_mask
		|-> ##[1:2] !low_power_stop)
		else $error("stop mode not left");
endmodule

// file: verif/cfb_ext_model.sv
/* External responder: memory and breakpoint circuitry on the engine pins.
   Assumes the bench picks a response mode per test, changed between cycles. */
`timescale 1ns/10ps
module cfb_ext_model
	import cfb_pkg::*;
(
	input wire logic		sys_clk,
	input wire cfb_pkg::cfb_bus_t	bus,
	input wire logic [1:0]		mode,
	input wire logic		hold_ack,
	output logic [1:0]		data_size_ack_n,
	output logic			bus_error_in_n,
	output wire logic [15:0]	data_in
);
	// Mode: 0 silent, 1 word acknowledge, 2 bus error, 3 byte acknowledge
	logic [15:0] junk_q = 16'h5a5a;
	initial data_size_ack_n = 2'h3;
	initial bus_error_in_n = 1'b1;
	// Released bus toggles so a stale word cannot pass for fresh data
	always @(posedge sys_clk) junk_q <= ~junk_q;
	assign data_in = bus.address_strobe_n ? junk_q : {bus.addr[7:0], ~bus.addr[7:0]};
	always @(posedge sys_clk) begin
		if (!bus.address_strobe_n) begin
			data_size_ack_n <= mode == 2'h1 ? ACK_16BIT_N :
				mode == 2'h3 ? ACK_8BIT_N : 2'h3;
			bus_error_in_n <= mode != 2'h2;
		end else begin
			data_size_ack_n <= hold_ack ? ACK_16BIT_N : 2'h3;
			bus_error_in_n <= 1'b1;
		end
	end
endmodule

// file: verif/tb_cfb_engine.sv
/* Bench for cfb_engine: hand-written scenarios against the external responder.
   Assumes the design package, responder and checker files are compiled first. */
`timescale 1ns/10ps
module tb_cfb_engine;
	import cfb_pkg::*;
	logic sys_clk = 0, reset_n = 0, req_valid = 0, bus_owned = 1, hold_ack = 0;
	logic breakpoint_pin_n = 1, fetch_is_prefetch = 0, pipe_flush = 0, instr_end = 0;
	logic [2:0] irq_level = 0;
	logic [1:0] mode = 0;
	cfb_req_t req = '0;
	cfb_cs_t cs = '0;
	logic [1:0] data_size_ack_n;
	logic bus_error_in_n, req_taken, data_oe, done, done_bus_error_in, illegal_trap, breakpoint_pin_trap;
	logic low_power_stop, ber, ill, as_q = 1;
	logic [15:0] data_in, data_out, rdata, rd, wd;
	logic [2:0] stop_mask;
	cfb_bus_t bus, cap;
	int miscompares = 0, tests_run = 0, nst, nbk = 0, dur, cyc_cnt = 0;
	cfb_engine uut (.sys_clk, .reset_n, .req, .req_valid, .req_taken, .cs, .bus_owned,
		.data_size_ack_n, .bus_error_in_n, .breakpoint_pin_n, .data_in, .data_out,
		.data_oe, .bus, .done, .done_bus_error_in, .rdata, .fetch_is_prefetch, .pipe_flush,
		.instr_end, .illegal_trap, .breakpoint_pin_trap, .low_power_stop, .stop_mask, .irq_level);
	cfb_ext_model ext (.sys_clk, .bus, .mode, .hold_ack, .data_size_ack_n,
		.bus_error_in_n, .data_in);
	always #12.5 sys_clk = ~sys_clk;
	// ----------------------------------------
	// Monitor and timeout
	// ----------------------------------------
	always @(negedge sys_clk) begin
		cyc_cnt++;
		if (bus.address_strobe_n === 1'b0 && as_q === 1'b1) begin
			cap = bus;
			nst++;
		end
		as_q = bus.address_strobe_n;
		if (data_oe === 1'b1) wd = data_out;
		if (breakpoint_pin_trap === 1'b1) nbk++;
		if (cyc_cnt == 3000) begin
			miscompares++;
			tally_and_finish;
		end
	end
	task chk(input string n, input logic [23:0] s, input logic [23:0] e);
		tests_run++;
		if (s !== e) begin
			miscompares++;
			$display("unexpected %s: expected %h seen %h", n, e, s);
		end
	endtask
	task automatic run(cfb_kind_t k, logic rw, logic [23:0] a, logic [15:0] d,
		logic [3:0] af);
		int n;
		@(posedge sys_clk);
		req <= '{k, rw, 3'h5, SIZE_WORD, a, d};
		cs <= '{1'b1, af}; // One matching select, strobe on address timing
		req_valid <= 1;
		nst = 0;
		n = 0;
		do begin @(negedge sys_clk); n++; end while (req_taken !== 1'b1 && n < 50);
		@(posedge sys_clk) req_valid <= 0;
		dur = 0;
		do begin @(negedge sys_clk); dur++; end while (done !== 1'b1 && dur < 60);
		ber = done_bus_error_in;
		ill = illegal_trap;
		rd = rdata;
		chk("request taken", 24'(n), 2);
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task t_fast;
		run(CFB_K_NORMAL, 1, 24'h001234, 16'h0, ACK_FAST);
		chk("fast read time", 24'(dur), 3);
		chk("fast read data", rd, 16'h34cb);
		run(CFB_K_NORMAL, 0, 24'h002468, 16'ha5c3, ACK_FAST);
		chk("fast write time", 24'(dur), 3);
		chk("fast write data", wd, 16'ha5c3);
		chk("fast addr", cap.addr, 24'h002468);
		chk("fast size", cap.transfer_size, SIZE_WORD);
		$display("fast test ended");
	endtask
	task t_regular;
		int d0;
		@(posedge sys_clk) mode <= 1;
		hold_ack <= 1;
		repeat (3) @(posedge sys_clk);
		run(CFB_K_NORMAL, 1, 24'h000100, 16'h0, ACK_EXT_ONLY);
		chk("held ack time", 24'(dur), 4);
		run(CFB_K_NORMAL, 1, 24'h000102, 16'h0, ACK_FAST);
		chk("held ack fast time", 24'(dur), 3);
		@(posedge sys_clk) mode <= 0;
		hold_ack <= 0;
		repeat (4) @(posedge sys_clk);
		run(CFB_K_NORMAL, 1, 24'h000104, 16'h0, 4'h2);
		d0 = dur;
		run(CFB_K_NORMAL, 1, 24'h000106, 16'h0, 4'h6);
		chk("wait state span", 24'(dur - d0), 4);
		run(CFB_K_NORMAL, 0, 24'h000108, 16'h1357, 4'h0);
		chk("regular write time", 24'(dur), 4);
		chk("regular write data", wd, 16'h1357);
		$display("regular test ended");
	endtask
	task t_sw;
		@(posedge sys_clk) mode <= 2;
		run(CFB_K_NORMAL, 1, 24'h000200, 16'h0, ACK_EXT_ONLY);
		chk("normal bus_error_in", {ber, ill}, 2'h2);
		run(CFB_K_SWBKPT, 1, 24'h0, 16'h0005, ACK_EXT_ONLY);
		chk("sw type", cap.addr[19:16], CPU_BREAKPOINT_PIN);
		chk("sw number", cap.addr[4:1], 4'ha);
		chk("sw space", cap.space_code, SPACE_CPU);
		chk("sw bus_error_in", {ber, ill}, 2'h3);
		@(posedge sys_clk) mode <= 3;
		repeat (3) @(posedge sys_clk);
		run(CFB_K_SWBKPT, 1, 24'h0, 16'h0002, ACK_EXT_ONLY);
		chk("sw byte word", rd, 16'h0809);
		chk("sw byte reads", 24'(nst), 2);
		chk("sw ack end", {ber, ill}, 2'h0);
		$display("software breakpoint test ended");
	endtask
	task automatic t_hw(logic [1:0] m, logic pf, logic fl, logic [23:0] e);
		int b0;
		@(posedge sys_clk) mode <= m;
		repeat (3) @(posedge sys_clk);
		fetch_is_prefetch <= pf;
		cs <= '{1'b1, ACK_EXT_ONLY};
		breakpoint_pin_n <= 0;
		b0 = nbk;
		repeat (3) @(posedge sys_clk);
		breakpoint_pin_n <= 1;
		dur = 0;
		do begin @(negedge sys_clk); dur++; end while (done !== 1'b1 && dur < 40);
		chk("hw breakpoint_pin addr", cap.addr[19:1], 19'h0000f);
		chk("hw breakpoint_pin read", cap.rw, 1);
		@(posedge sys_clk) pipe_flush <= fl;
		@(posedge sys_clk) pipe_flush <= 0;
		instr_end <= 1;
		@(posedge sys_clk) instr_end <= 0;
		repeat (3) @(posedge sys_clk);
		chk("hw breakpoint_pin traps", 24'(nbk - b0), e);
		$display("hardware breakpoint test ended");
	endtask
	task t_stop;
		@(posedge sys_clk) bus_owned <= 0;
		wd = 16'h0000;
		mode <= 2;
		run(CFB_K_LOW_POWER_STOP, 0, LOW_POWER_STOP_ADDR, 16'h0004, ACK_EXT_ONLY);
		chk("stop hidden", 24'(nst), 0);
		chk("stop hidden data", wd, 16'h0000);
		repeat (2) @(negedge sys_clk);
		chk("stop mode", {low_power_stop, stop_mask}, 4'hc);
		@(posedge sys_clk) irq_level <= 4;
		repeat (3) @(negedge sys_clk);
		chk("stop equal irq", low_power_stop, 1);
		@(posedge sys_clk) irq_level <= 5;
		repeat (3) @(negedge sys_clk);
		chk("stop left", low_power_stop, 0);
		@(posedge sys_clk) bus_owned <= 1;
		irq_level <= 0;
		run(CFB_K_LOW_POWER_STOP, 0, LOW_POWER_STOP_ADDR, 16'h0001, ACK_EXT_ONLY);
		chk("stop addr", cap.addr, LOW_POWER_STOP_ADDR);
		chk("stop space", cap.space_code, SPACE_CPU);
		chk("stop time", 24'(dur), 3);
		chk("stop mask word", wd[2:0], 3'h1);
		chk("stop bus_error_in", ber, 0);
		@(posedge sys_clk) irq_level <= 7;
		$display("stop test ended");
	endtask
	task tally_and_finish;
		$display("comparisons %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial begin
		repeat (2) @(posedge sys_clk);
		reset_n <= 1;
		repeat (3) @(posedge sys_clk);
		t_fast;
		t_regular;
		t_sw;
		t_hw(2'h2, 1, 0, 1);
		t_hw(2'h1, 1, 0, 0);
		t_hw(2'h2, 1, 1, 0);
		t_hw(2'h2, 0, 1, 1);
		t_stop;
		tally_and_finish;
	end
endmodule
bind cfb_engine cfb_engine_checker chk (.sys_clk, .reset_n, .cs, .data_size_ack_n, .bus,
	.done, .done_bus_error_in, .illegal_trap, .low_power_stop, .stop_mask, .irq_level);
